// file: include/pio_pkg.sv
// constants shared by both ends of the parallel i/o channel and its bus
// assumes a 200 MHz clock shared by host and channel, single-word transfers
// What this block does
// [RL1] host inputs while unbuffered input data stands
// [RL2] device captures output data during output strobe
// [RL3] three control pulse lines, two sense lines
// [RL4] buffered variant holds one 16-bit word
// [RL5] buffered output load clears ready
// [RL6] device load strobe trailing edge sets ready
// [RL7] drop-in trailing edge loads word, sets ready
// [RL8] mask set plus ready raises interrupt
// [RL9] ready testable by input or sense skip
// [RL10] host selects direction before buffered transfers
// [RL11] channel address digit 4, 5 or 6
// [RL12] clear-and-input: clear, or in, skip if ready
// [RL13] plain input: or in without clearing
// [RL14] conditional output: strobe data, skip if ready
// [RL15] host selects input mode before input
// [RL16] codes 1, 2, 4 pulse control lines
// [RL17] block-transfer enable requests while ready; range end clears
// [RL18] enable after input select, before output select
// [RL19] stop code clears end-of-range interrupt
// [RL20] sense-skip ready code skips when ready
// [RL21] sense codes skip when user line set
// [RL22] mask plus end of range raises interrupt
// [RL23] mask word bits 5, 6, 7 per channel
// [RL24] reset clears ready, direction, enable, mask
package pio_pkg;
	localparam int DATA_W = 16;

	// command kinds on the i/o bus
	localparam logic [2:0] KIND_INPUT_TO_ACCUMULATOR       = 3'h0;
	localparam logic [2:0] KIND_OUTPUT_FROM_ACCUMULATOR    = 3'h1;
	localparam logic [2:0] KIND_OUTPUT_CONTROL_PULSE       = 3'h2;
	localparam logic [2:0] KIND_SKIP_ON_SENSE              = 3'h3;
	localparam logic [2:0] KIND_MULTIPLEXED_BLOCK_TRANSFER = 3'h4;  // one block cycle

	// function codes (high digits of the address field)
	localparam logic [3:0] FN_PLAIN = 4'h0;
	localparam logic [3:0] FN_SEL1  = 4'h1;
	localparam logic [3:0] FN_SEL2  = 4'h2;
	localparam logic [3:0] FN_SEL3  = 4'h4;
	localparam logic [3:0] FN_STOP  = 4'h7;
	localparam logic [3:0] FN_CLR   = 4'h8;

	// device codes: channel n answers at base + 4 + (n-1)
	localparam logic [5:0] DEV_BASE  = 6'h18;
	localparam logic [5:0] DIGIT_CH1 = 6'h04;
	localparam logic [5:0] MASK_DEV  = 6'h10;
	localparam int         MASK_BIT_CH1 = 11;  // word bit 5, msb-first numbering

	// variants
	localparam int VAR_INPUT    = 0;
	localparam int VAR_OUTPUT   = 1;
	localparam int VAR_BUFFERED = 2;

	// output strobe widths
	localparam int CLK_PS      = 5000;
	localparam int OTP_STD_NS  = 3000;
	localparam int OTP_BLOCK_NS  = 1000;
	localparam int OTP_STD_CYC = OTP_STD_NS * 1000 / CLK_PS;
	localparam int OTP_BLOCK_CYC = OTP_BLOCK_NS * 1000 / CLK_PS;
	localparam int OTP_CNT_W   = 10;

	// host register map (word index on avalon)
	localparam logic [1:0] REG_CMD    = 2'h0;
	localparam logic [1:0] REG_ACC    = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	// command register fields
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_FUNC_LSB = 3;
	localparam int CMD_DEV_LSB  = 7;
	localparam int CMD_ERL_BIT  = 13;
	// status register fields
	localparam int ST_BUSY  = 0;
	localparam int ST_SKIP  = 1;
	localparam int ST_IRQ   = 2;
	localparam int ST_DIL   = 3;
	localparam int ST_READY = 4;
endpackage

// file: include/pio_if.sv
// i/o bus between the host end and one parallel channel
// assumes both ends share clock; no tristate, one channel on the bus
`timescale 1ns/1ps
interface pio_if;
	logic        cmd_valid;  // one-cycle command pulse
	logic [2:0]  cmd_kind;   // command kind
	logic [3:0]  cmd_func;   // function code
	logic [5:0]  cmd_dev;    // device code
	logic [15:0] obus;       // output bus (accumulator)
	logic        erl;        // end of range with a block cycle
	logic        resp_valid; // addressed channel answered
	logic        skip;       // skip the next instruction
	logic [15:0] ibus;       // input bus
	logic        irq;        // standard interrupt line
	logic        dil;        // block-transfer request
	logic        ready;      // channel ready line

	modport host_end (output cmd_valid, cmd_kind, cmd_func, cmd_dev, obus, erl,
		input resp_valid, skip, ibus, irq, dil, ready);
	modport device_end (input cmd_valid, cmd_kind, cmd_func, cmd_dev, obus, erl,
		output resp_valid, skip, ibus, irq, dil, ready);
endinterface

// file: logic/pio_channel.sv
// parallel channel: device end of the i/o bus, in one of three variants
// assumes device pins are asynchronous; the host keeps direction order
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module pio_channel #(
	parameter int CHAN        = 1,                     // 1..3 in a system
	parameter int VARIANT     = pio_pkg::VAR_BUFFERED, // input, output, buffered
	parameter bit BLOCK_FITTED = 1'b1,                 // block-transfer subchannel
	parameter bit STOP_FITTED = 1'b1                   // end-of-range interrupt
) (
	input  wire logic        clock,        // 200 MHz
	input  wire logic        rst,          // synchronous, active high
	pio_if.device_end        bus,          // host i/o bus
	input  wire logic [15:0] dev_data_in,  // device input word
	input  wire logic        drop_in,      // device drop-in pulse
	input  wire logic        load_strobe,  // device took output word
	input  wire logic        dev_ready,    // unbuffered device ready
	input  wire logic [1:0]  sense_line,   // user sense lines 1, 2
	output logic      [15:0] dev_data_out, // word to device
	output logic             otp,          // output strobe
	output logic      [2:0]  ctl_line      // user control pulses 1..3
);
	if (CHAN < 1 || CHAN > 3)
		$error("channel number must be 1 to 3");
	if (VARIANT < pio_pkg::VAR_INPUT || VARIANT > pio_pkg::VAR_BUFFERED)
		$error("unknown channel variant");

	localparam logic [5:0] MY_DEV = pio_pkg::DEV_BASE + pio_pkg::DIGIT_CH1 + 6'(CHAN - 1); // see [RL11]
	localparam int         MASK_BIT = pio_pkg::MASK_BIT_CH1 - (CHAN - 1);
	localparam bit IS_BUF = (VARIANT == pio_pkg::VAR_BUFFERED);
	localparam logic [pio_pkg::OTP_CNT_W-1:0] OTP_STD = pio_pkg::OTP_CNT_W'(pio_pkg::OTP_STD_CYC);
	localparam logic [pio_pkg::OTP_CNT_W-1:0] OTP_BLOCK = pio_pkg::OTP_CNT_W'(pio_pkg::OTP_BLOCK_CYC);

	typedef struct packed {
		logic [15:0] word;      // buffer, see [RL4]
		logic        rdy;
		logic        dir_out;
		logic        block_en;
		logic        mask;
		logic        stop_irq;
		logic [2:0]  ctl;
		logic        otp;
		logic [pio_pkg::OTP_CNT_W-1:0] otp_cnt;
		logic        resp;
		logic        skip;
		logic [15:0] ibus;
		logic        din_s1, din_s2, din_p;
		logic        ld_s1, ld_s2, ld_p;
		logic        rdy_s1, rdy_s2;
		logic [1:0]  sen_s1, sen_s2;
		logic [15:0] dat_s1, dat_s2;
	} chan_t;

	chan_t q_r, q_nxt;
	logic  rdy_now;
	logic  can_in;
	logic  can_out;
	logic  irq_now;
	logic  mine;

	// ready as seen by the host: flip-flop when buffered, pin otherwise
	always_comb begin
		if (IS_BUF)
			rdy_now = q_r.rdy;
		else if (VARIANT == pio_pkg::VAR_OUTPUT)
			rdy_now = q_r.rdy_s2 & ~q_r.otp; // busy while strobing
		else
			rdy_now = q_r.rdy_s2;
		can_in  = (VARIANT == pio_pkg::VAR_INPUT) | (IS_BUF & ~q_r.dir_out);
		can_out = (VARIANT == pio_pkg::VAR_OUTPUT) | (IS_BUF & q_r.dir_out);
		irq_now = q_r.mask & (rdy_now | (STOP_FITTED & q_r.stop_irq)); // see [RL8] see [RL22]
		mine    = bus.cmd_valid & (bus.cmd_dev == MY_DEV);
	end

	// next state; device-side sets come last so they win over clears
	always_comb begin
		q_nxt      = q_r;
		q_nxt.resp = 1'b0;
		q_nxt.skip = 1'b0;
		q_nxt.ibus = 16'h0000;
		q_nxt.ctl  = 3'h0;
		// two-stage synchronisers, third stage only for edges
		q_nxt.din_s1 = drop_in;
		q_nxt.din_s2 = q_r.din_s1;
		q_nxt.din_p  = q_r.din_s2;
		q_nxt.ld_s1  = load_strobe;
		q_nxt.ld_s2  = q_r.ld_s1;
		q_nxt.ld_p   = q_r.ld_s2;
		q_nxt.rdy_s1 = dev_ready;
		q_nxt.rdy_s2 = q_r.rdy_s1;
		q_nxt.sen_s1 = sense_line;
		q_nxt.sen_s2 = q_r.sen_s1;
		q_nxt.dat_s1 = dev_data_in;
		q_nxt.dat_s2 = q_r.dat_s1;
		if (q_r.otp_cnt != '0)
			q_nxt.otp_cnt = q_r.otp_cnt - 1'b1;

		// mask word goes to every channel at once
		if (bus.cmd_valid && bus.cmd_kind == pio_pkg::KIND_OUTPUT_FROM_ACCUMULATOR
			&& bus.cmd_dev == pio_pkg::MASK_DEV && bus.cmd_func == pio_pkg::FN_PLAIN)
			q_nxt.mask = bus.obus[MASK_BIT]; // see [RL23]

		if (mine) begin
			q_nxt.resp = 1'b1;
			case (bus.cmd_kind)
				pio_pkg::KIND_INPUT_TO_ACCUMULATOR: begin
					// input only when the host has set input mode, see [RL15] see [RL1]
					if ((bus.cmd_func == pio_pkg::FN_CLR || bus.cmd_func == pio_pkg::FN_PLAIN)
						&& can_in && rdy_now) begin
						q_nxt.skip = 1'b1; // see [RL9] see [RL12] see [RL13]
						q_nxt.ibus = IS_BUF ? q_r.word : q_r.dat_s2;
						if (IS_BUF)
							q_nxt.rdy = 1'b0; // word consumed
					end
				end
				pio_pkg::KIND_OUTPUT_FROM_ACCUMULATOR: begin
					if (bus.cmd_func == pio_pkg::FN_PLAIN && can_out && rdy_now) begin
						q_nxt.skip    = 1'b1; // see [RL14]
						q_nxt.word    = bus.obus;
						q_nxt.otp_cnt = OTP_STD; // see [RL2]
						if (IS_BUF)
							q_nxt.rdy = 1'b0; // see [RL5] see [RL6]
					end
				end
				pio_pkg::KIND_OUTPUT_CONTROL_PULSE: begin
					case (bus.cmd_func)
						pio_pkg::FN_PLAIN: q_nxt.block_en = BLOCK_FITTED; // see [RL17] see [RL18]
						pio_pkg::FN_SEL1: begin
							q_nxt.ctl[0] = 1'b1; // see [RL3] see [RL16]
							if (IS_BUF)
								q_nxt.dir_out = 1'b0; // see [RL10]
						end
						pio_pkg::FN_SEL2: begin
							q_nxt.ctl[1] = 1'b1; // see [RL16]
							if (IS_BUF) begin
								q_nxt.dir_out = 1'b1; // buffer free for the first word
								q_nxt.rdy     = 1'b1;
							end
						end
						pio_pkg::FN_SEL3: q_nxt.ctl[2] = 1'b1; // see [RL16]
						pio_pkg::FN_STOP: begin
							if (STOP_FITTED)
								q_nxt.stop_irq = 1'b0; // see [RL19]
						end
						default: q_nxt.ctl = 3'h0;
					endcase
				end
				pio_pkg::KIND_SKIP_ON_SENSE: begin
					case (bus.cmd_func)
						pio_pkg::FN_PLAIN: q_nxt.skip = rdy_now;          // see [RL20] see [RL9]
						pio_pkg::FN_SEL1:  q_nxt.skip = q_r.sen_s2[1];    // see [RL21]
						pio_pkg::FN_SEL2:  q_nxt.skip = q_r.sen_s2[0];    // see [RL21]
						pio_pkg::FN_SEL3:  q_nxt.skip = ~irq_now;
						default:           q_nxt.skip = 1'b0;
					endcase
				end
				pio_pkg::KIND_MULTIPLEXED_BLOCK_TRANSFER: begin
					// one block-transfer word per grant
					if (q_r.block_en) begin
						if (can_out) begin
							q_nxt.word    = bus.obus;
							q_nxt.otp_cnt = OTP_BLOCK; // see [RL2]
						end else begin
							q_nxt.skip = 1'b1;
							q_nxt.ibus = IS_BUF ? q_r.word : q_r.dat_s2;
						end
						if (IS_BUF)
							q_nxt.rdy = 1'b0;
						if (bus.erl) begin
							q_nxt.block_en = 1'b0; // see [RL17]
							if (STOP_FITTED)
								q_nxt.stop_irq = 1'b1; // see [RL22]
						end
					end
				end
				default: q_nxt.resp = 1'b1;
			endcase
		end

		// trailing edges from the device set ready, winning over any clear
		if (IS_BUF && !q_r.dir_out && q_r.din_p && !q_r.din_s2) begin
			q_nxt.word = q_r.dat_s2; // see [RL7]
			q_nxt.rdy  = 1'b1;
		end
		if (IS_BUF && q_r.dir_out && q_r.ld_p && !q_r.ld_s2)
			q_nxt.rdy = 1'b1; // see [RL6]
		q_nxt.otp = (q_nxt.otp_cnt != '0);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q_r <= '0; // see [RL24]
		end else begin
			q_r <= q_nxt;
		end
	end

	// outputs
	assign dev_data_out   = q_r.word;
	assign otp            = q_r.otp;
	assign ctl_line       = q_r.ctl;
	assign bus.resp_valid = q_r.resp;
	assign bus.skip       = q_r.skip;
	assign bus.ibus       = q_r.ibus;
	assign bus.irq        = irq_now;
	assign bus.dil        = q_r.block_en & rdy_now; // see [RL17]
	assign bus.ready      = rdy_now;
endmodule

// file: logic/pio_host.sv
// host end: avalon-mm register slave that issues i/o bus commands
// assumes one channel answers one cycle after a command, or none does
`timescale 1ns/1ps
module pio_host (
	input  wire logic        clock,           // 200 MHz
	input  wire logic        rst,             // synchronous, active high
	input  wire logic [1:0]  avs_address,     // word index
	input  wire logic        avs_read,        // read request
	input  wire logic        avs_write,       // write request
	input  wire logic [31:0] avs_writedata,   // write data
	output logic      [31:0] avs_readdata,    // read data
	output logic             avs_waitrequest, // hold request
	pio_if.host_end          bus              // i/o bus
);
	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_ISSUE = 3'b010,
		S_WAIT  = 3'b100
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		logic [2:0]  kind;
		logic [3:0]  func;
		logic [5:0]  dev;
		logic        erl;
		logic [15:0] acc;
		logic        last_skip;
		logic        rd_done;
		logic [31:0] rdata;
	} host_t;

	host_t q_r, q_nxt;
	logic  cmd_wr;
	logic  acc_wr;
	logic  [31:0] status_w;

	// a command write stalls until its answer is in; reads stall one cycle
	always_comb begin
		cmd_wr = avs_write & (avs_address == pio_pkg::REG_CMD);
		acc_wr = avs_write & (avs_address == pio_pkg::REG_ACC);
		avs_waitrequest = (avs_read & ~q_r.rd_done)
			| (cmd_wr & (q_r.st != S_WAIT))
			| (acc_wr & (q_r.st != S_IDLE));
		status_w = 32'h0000_0000;
		status_w[pio_pkg::ST_BUSY]  = (q_r.st != S_IDLE);
		status_w[pio_pkg::ST_SKIP]  = q_r.last_skip;
		status_w[pio_pkg::ST_IRQ]   = bus.irq;
		status_w[pio_pkg::ST_DIL]   = bus.dil;
		status_w[pio_pkg::ST_READY] = bus.ready;
	end

	always_comb begin
		q_nxt         = q_r;
		q_nxt.rd_done = avs_read & ~q_r.rd_done;
		if (avs_read && !q_r.rd_done) begin
			case (avs_address)
				pio_pkg::REG_ACC:    q_nxt.rdata = {16'h0000, q_r.acc};
				pio_pkg::REG_STATUS: q_nxt.rdata = status_w;
				default:             q_nxt.rdata = 32'h0000_0000;
			endcase
		end
		case (q_r.st)
			S_IDLE: begin
				if (acc_wr)
					q_nxt.acc = avs_writedata[15:0];
				if (cmd_wr) begin
					q_nxt.kind = avs_writedata[pio_pkg::CMD_KIND_LSB +: 3];
					q_nxt.func = avs_writedata[pio_pkg::CMD_FUNC_LSB +: 4];
					q_nxt.dev  = avs_writedata[pio_pkg::CMD_DEV_LSB +: 6];
					q_nxt.erl  = avs_writedata[pio_pkg::CMD_ERL_BIT];
					q_nxt.st   = S_ISSUE;
				end
			end
			S_ISSUE: q_nxt.st = S_WAIT;
			S_WAIT: begin
				// no answer means no skip
				q_nxt.last_skip = bus.resp_valid & bus.skip;
				if (bus.resp_valid && bus.skip) begin
					if (q_r.kind == pio_pkg::KIND_INPUT_TO_ACCUMULATOR)
						q_nxt.acc = ((q_r.func == pio_pkg::FN_CLR) ? 16'h0000 : q_r.acc) | bus.ibus; // see [RL12] see [RL13]
					else if (q_r.kind == pio_pkg::KIND_MULTIPLEXED_BLOCK_TRANSFER)
						q_nxt.acc = bus.ibus;
				end
				q_nxt.st = S_IDLE;
			end
			default: q_nxt.st = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q_r <= '{st: S_IDLE, default: '0};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign avs_readdata  = q_r.rdata;
	assign bus.cmd_valid = (q_r.st == S_ISSUE);
	assign bus.cmd_kind  = q_r.kind;
	assign bus.cmd_func  = q_r.func;
	assign bus.cmd_dev   = q_r.dev;
	assign bus.obus      = q_r.acc; // see [RL14]
	assign bus.erl       = q_r.erl;
endmodule

// file: bench/pio_assertions.sv
// checker for the i/o bus joining the host end to one channel
// assumes one buffered channel, first in the system, on a shared clock
`timescale 1ns/1ps
module pio_assertions #(
	parameter logic [5:0] DEV = 6'h1C // channel address
) (
	input wire logic       clock,      // bus clock
	input wire logic       rst,        // sync reset
	input wire logic       cmd_valid,  // command pulse
	input wire logic [2:0] cmd_kind,   // command kind
	input wire logic [3:0] cmd_func,   // function code
	input wire logic [5:0] cmd_dev,    // device code
	input wire logic       erl,        // end of range
	input wire logic       resp_valid, // channel answer
	input wire logic       skip,       // skip flag
	input wire logic       irq,        // interrupt line
	input wire logic       dil,        // block request
	input wire logic       ready       // ready line
);
	// command addressed to this channel
	wire hit = cmd_valid && cmd_dev == DEV;
	wire xfer = cmd_kind == pio_pkg::KIND_INPUT_TO_ACCUMULATOR
		|| cmd_kind == pio_pkg::KIND_OUTPUT_FROM_ACCUMULATOR;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// answers are tied to the address one cycle earlier
	resp_hit_a: assert property (hit |=> resp_valid)
		else $error("own address not answered");
	resp_other_a: assert property (cmd_valid && cmd_dev != DEV |=> !resp_valid && !skip)
		else $error("answer to foreign address");
	resp_cause_a: assert property (resp_valid |-> $past(hit))
		else $error("answer without command");
	sense_ready_a: assert property (hit && cmd_kind == pio_pkg::KIND_SKIP_ON_SENSE
		&& cmd_func == pio_pkg::FN_PLAIN |=> skip == $past(ready))
		else $error("ready sense skip wrong");
	no_ready_a: assert property (hit && xfer && !ready |=> !skip)
		else $error("transfer skipped while not ready");
	take_ready_a: assert property (hit && cmd_kind == pio_pkg::KIND_OUTPUT_FROM_ACCUMULATOR
		&& ready |=> skip && !ready)
		else $error("output load kept ready");
	dil_ready_a: assert property (dil |-> ready)
		else $error("block request without ready");
	erl_stop_a: assert property (hit && cmd_kind == pio_pkg::KIND_MULTIPLEXED_BLOCK_TRANSFER
		&& erl |=> !dil)
		else $error("range end left block mode on");
	rst_clear_a: assert property (disable iff (1'b0) rst |=> !ready && !dil && !irq)
		else $error("reset left state set");
endmodule

// file: bench/parallel_io_channel_test.sv
// self-checking bench: avalon master on the host end, device pins on the channel
// assumes a buffered first channel with block transfer and stop interrupt fitted
`timescale 1ns/1ps
module parallel_io_channel_test;
	localparam logic [5:0] CH = 6'h1C;
	logic        clock;
	logic        rst;
	logic [1:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic        wreq;
	logic [15:0] din;
	logic        drop_in;
	logic        load_strobe;
	logic [1:0]  sense;
	logic [15:0] dout;
	logic        otp;
	logic [2:0]  ctl;
	logic [2:0]  ctl_seen;
	int          otp_run;
	int          otp_last;
	int          err_count;
	int          n_compared;
	logic [31:0] q;

	pio_if i_pio_if ();
	pio_host i_pio_host (.clock(clock), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .bus(i_pio_if));
	pio_channel i_pio_channel (.clock(clock), .rst(rst), .bus(i_pio_if), .dev_data_in(din),
		.drop_in(drop_in), .load_strobe(load_strobe), .dev_ready(1'b0), .sense_line(sense),
		.dev_data_out(dout), .otp(otp), .ctl_line(ctl));
	pio_assertions i_pio_assertions (.clock(clock), .rst(rst), .cmd_valid(i_pio_if.cmd_valid),
		.cmd_kind(i_pio_if.cmd_kind), .cmd_func(i_pio_if.cmd_func), .cmd_dev(i_pio_if.cmd_dev),
		.erl(i_pio_if.erl), .resp_valid(i_pio_if.resp_valid), .skip(i_pio_if.skip), .irq(i_pio_if.irq),
		.dil(i_pio_if.dil), .ready(i_pio_if.ready));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// pulses last one cycle, so latch them; strobe width is counted
	always @(posedge clock) begin
		if (rst) begin
			ctl_seen <= 3'b000;
			otp_run  <= 0;
			otp_last <= 0;
		end else begin
			ctl_seen <= ctl_seen | ctl;
			otp_run  <= otp ? otp_run + 1 : 0;
			if (!otp && otp_run != 0)
				otp_last <= otp_run;
		end
	end

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// avalon transfer; request held until waitrequest is seen low at a rising edge
	// one idle cycle after release, so back-to-back calls never touch a strobe twice
	task automatic xfer(input logic w, input logic [1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd  <= d;
		wr  <= w;
		rd  <= !w;
		@(posedge clock);
		while (wreq !== 1'b0) begin
			n++;
			if (n > 100) begin
				err_count++;
				end_sim();
			end
			@(posedge clock);
		end
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clock);
	endtask

	task automatic stat(input int b, input logic e);
		chk({31'h0, q[b]}, {31'h0, e});
	endtask

	// one bus command, then status read and skip compare
	task automatic cmd(input logic [2:0] k, input logic [3:0] f, input logic [5:0] dv, input logic e,
		input logic s);
		xfer(1'b1, pio_pkg::REG_CMD, {18'h0, e, dv, f, k});
		xfer(1'b0, pio_pkg::REG_STATUS, 32'h0000_0000);
		stat(pio_pkg::ST_SKIP, s);
	endtask

	task automatic acc(input logic [15:0] v);
		xfer(1'b1, pio_pkg::REG_ACC, {16'h0000, v});
	endtask

	// device pulse, then time for the pin synchronisers
	task automatic pulse(input logic load);
		if (load)
			load_strobe <= 1'b1;
		else
			drop_in <= 1'b1;
		repeat (6) @(posedge clock);
		drop_in <= 1'b0;
		load_strobe <= 1'b0;
		repeat (6) @(posedge clock);
	endtask

	initial begin
		{rst, adr, rd, wr, wd, din, drop_in, load_strobe} = {1'b1, 54'h0};
		{sense, err_count, n_compared} = {2'b01, 64'h0};
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		xfer(1'b0, pio_pkg::REG_STATUS, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		cmd(pio_pkg::KIND_OUTPUT_CONTROL_PULSE, pio_pkg::FN_SEL1, CH, 1'b0, 1'b0);
		din <= 16'hA5C3; // word stands until it is read
		pulse(1'b0);
		cmd(pio_pkg::KIND_SKIP_ON_SENSE, pio_pkg::FN_PLAIN, 6'h1D, 1'b0, 1'b0);
		cmd(pio_pkg::KIND_SKIP_ON_SENSE, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b1);
		acc(16'h1200);
		cmd(pio_pkg::KIND_INPUT_TO_ACCUMULATOR, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b1);
		cmd(pio_pkg::KIND_INPUT_TO_ACCUMULATOR, pio_pkg::FN_CLR, CH, 1'b0, 1'b0);
		xfer(1'b0, pio_pkg::REG_ACC, 32'h0000_0000);
		chk(q, 32'h0000_B7C3);
		din <= 16'h0081;
		pulse(1'b0);
		cmd(pio_pkg::KIND_INPUT_TO_ACCUMULATOR, pio_pkg::FN_CLR, CH, 1'b0, 1'b1);
		xfer(1'b0, pio_pkg::REG_ACC, 32'h0000_0000);
		chk(q, 32'h0000_0081);
		$display("test input done");
		for (int i = 0; i < 2; i++) begin
			sense <= i[0] ? 2'b10 : 2'b01;
			repeat (4) @(posedge clock);
			cmd(pio_pkg::KIND_SKIP_ON_SENSE, pio_pkg::FN_SEL1, CH, 1'b0, i[0]);
			cmd(pio_pkg::KIND_SKIP_ON_SENSE, pio_pkg::FN_SEL2, CH, 1'b0, !i[0]);
		end
		acc(16'h0800);
		cmd(pio_pkg::KIND_OUTPUT_FROM_ACCUMULATOR, pio_pkg::FN_PLAIN, pio_pkg::MASK_DEV, 1'b0, 1'b0);
		pulse(1'b0);
		xfer(1'b0, pio_pkg::REG_STATUS, 32'h0000_0000);
		stat(pio_pkg::ST_IRQ, 1'b1);
		// interrupting channel must not skip on the not-interrupting test
		cmd(pio_pkg::KIND_SKIP_ON_SENSE, pio_pkg::FN_SEL3, CH, 1'b0, 1'b0);
		cmd(pio_pkg::KIND_OUTPUT_CONTROL_PULSE, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b0);
		stat(pio_pkg::ST_DIL, 1'b1);
		cmd(pio_pkg::KIND_MULTIPLEXED_BLOCK_TRANSFER, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b1);
		pulse(1'b0);
		cmd(pio_pkg::KIND_MULTIPLEXED_BLOCK_TRANSFER, pio_pkg::FN_PLAIN, CH, 1'b1, 1'b1);
		stat(pio_pkg::ST_IRQ, 1'b1);
		cmd(pio_pkg::KIND_OUTPUT_CONTROL_PULSE, pio_pkg::FN_STOP, CH, 1'b0, 1'b0);
		stat(pio_pkg::ST_IRQ, 1'b0);
		cmd(pio_pkg::KIND_SKIP_ON_SENSE, pio_pkg::FN_SEL3, CH, 1'b0, 1'b1);
		pulse(1'b0);
		xfer(1'b0, pio_pkg::REG_STATUS, 32'h0000_0000);
		stat(pio_pkg::ST_DIL, 1'b0);
		$display("test block input done");
		cmd(pio_pkg::KIND_OUTPUT_CONTROL_PULSE, pio_pkg::FN_SEL3, CH, 1'b0, 1'b0);
		cmd(pio_pkg::KIND_OUTPUT_CONTROL_PULSE, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b0);
		cmd(pio_pkg::KIND_OUTPUT_CONTROL_PULSE, pio_pkg::FN_SEL2, CH, 1'b0, 1'b0);
		chk({29'h0, ctl_seen}, 32'h0000_0007);
		acc(16'h5A3C);
		cmd(pio_pkg::KIND_MULTIPLEXED_BLOCK_TRANSFER, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b0);
		chk({16'h0000, dout}, 32'h0000_5A3C);
		repeat (220) @(posedge clock);
		chk(32'(otp_last), 32'(pio_pkg::OTP_BLOCK_CYC));
		pulse(1'b1);
		acc(16'hC3A5);
		cmd(pio_pkg::KIND_OUTPUT_FROM_ACCUMULATOR, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b1);
		stat(pio_pkg::ST_READY, 1'b0);
		cmd(pio_pkg::KIND_OUTPUT_FROM_ACCUMULATOR, pio_pkg::FN_PLAIN, CH, 1'b0, 1'b0);
		repeat (620) @(posedge clock);
		chk(32'(otp_last), 32'(pio_pkg::OTP_STD_CYC));
		chk({16'h0000, dout}, 32'h0000_C3A5);
		$display("test output done");
		end_sim();
	end
endmodule
